/* File: src/utd_pkg.sv */
// Constants for the transmit descriptor DMA engine.
// Assumes 32-bit descriptor words in byte-addressed main memory.
package utd_pkg;
  // Register port map, byte addresses; per channel block of 32 bytes
  localparam logic [8:0] CH_STRIDE    = 9'h020;
  localparam logic [2:0] W_HEAD       = 3'h0;
  localparam logic [2:0] W_FIRST      = 3'h1;
  localparam logic [2:0] W_CURDESC    = 3'h2;
  localparam logic [2:0] W_CURBUF     = 3'h3;
  localparam logic [2:0] W_SCRATCH    = 3'h4;
  localparam logic [2:0] W_LENGTH     = 3'h5;
  localparam logic [2:0] W_COMP       = 3'h6;
  localparam logic [8:0] INT_STAT_OFS = 9'h100;
  localparam logic [8:0] INT_MASK_OFS = 9'h104;
  localparam logic [8:0] TALLY_OFS    = 9'h108;
  // Descriptor word three fields
  localparam int FIRST_BIT = 31;
  localparam int LAST_BIT  = 30;
  localparam int OWN_BIT   = 29;
  localparam int DRAIN_BIT = 28;
  localparam int ZLP_BIT   = 23;
  localparam int RXAB_BIT  = 19;
  localparam int PLEN_LSB  = 0;
  localparam int LEN_W     = 16;
  // Byte offsets inside a 16-byte descriptor
  localparam logic [31:0] CTL_OFS  = 32'h0000000c;
  localparam logic [31:0] WORD_INC = 32'h00000004;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  // Engine states, Gray in declaration order from ST_IDLE to ST_DONE
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_DESC  = 4'h1,
    ST_PARSE = 4'h3,
    ST_FETCH = 4'h7,
    ST_SEND  = 4'h5,
    ST_BEND  = 4'h4,
    ST_WBEOQ = 4'hc,
    ST_WBOWN = 4'hd,
    ST_DONE  = 4'hf,
    ST_RXRD  = 4'h8,
    ST_RXWR  = 4'h9
  } utd_state_e;
endpackage : utd_pkg

/* File: src/utd_tx_dma.sv */
// Transmit descriptor DMA engine: walks descriptor queues, feeds endpoint bytes.
// Assumes a memory master port with req/ack and an endpoint byte sink with ready.
// Function
// R1 - Word three bit 31 marks a packet's first buffer.
// R2 - Bit 30 marks the last buffer; both marks give a one-buffer packet.
// R3 - Bit 29 on the first buffer: engine owns it; cleared after sending.
// R4 - Engine sets bit 28 on the last buffer when the queue drains.
// R5 - Bit 23 requests a zero-length packet; no data is fetched.
// R6 - Receive abort sets bit 19 and zeroes the buffer tally.
// R7 - Packet length bits 15:0 truncate data beyond that length.
// R8 - Software keeps packet length nonzero, not above the buffer sum.
// R9 - Packets of any buffer count are walked correctly.
// R10 - Each channel keeps six state words and a completion pointer.
// R11 - Each channel serves one queue with head and completion pointers.
// R12 - State words: head, first, current desc, current buffer, lengths.
// R13 - Software appends at the tail; engine frees packets at the head.
// R14 - Reserved bits of word three are kept on write-back.
// R15 - Word zero links descriptors; a zero link ends the queue.
// R16 - Word two: offset high half on first buffers, byte count low.
// R17 - Writing a nonzero head pointer starts the channel.
// R18 - Completion pointer written per packet; matching write drops interrupt.
//
// Our own choices: the plain strobed port and the address map.
`default_nettype none
`timescale 1ns/1ps
module utd_tx_dma #(
  parameter int NUM_CH = 4
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Register port
  input  wire logic [8:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Memory master
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Endpoint byte stream
  output logic             ep_valid,
  output logic      [7:0]  ep_data,
  output logic             ep_last,
  output logic             ep_zlp,
  output logic      [2:0]  ep_chan,
  input  wire logic        ep_ready,
  // Receive abort event
  input  wire logic        rx_abort,
  input  wire logic [31:0] rx_first_desc,
  // Interrupt
  output logic             irq
);
  localparam int CHW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

  utd_pkg::utd_state_e st;
  logic [31:0] head_reg [NUM_CH];
  logic [31:0] first_reg [NUM_CH];
  logic [31:0] curd_reg [NUM_CH];
  logic [31:0] curb_reg [NUM_CH];
  logic [31:0] scr_reg [NUM_CH];
  logic [31:0] len_reg [NUM_CH];
  logic [31:0] comp_reg [NUM_CH];
  logic [NUM_CH:0] int_stat_reg;
  logic [NUM_CH:0] int_mask_reg;
  logic [15:0] tally_reg;
  logic        rx_pend_reg;
  logic [31:0] rx_desc_reg;
  logic [CHW-1:0] act;
  logic [31:0] cur, link, bufp, lenw, ctl, sopp, sop_ctl, addr;
  logic [15:0] bytes, remain, actual;
  logic [1:0]  widx;
  logic        in_pkt, eoq_q;
  logic [CHW-1:0] pick;
  logic        pick_v;
  logic [CHW-1:0] wch;
  logic        ch_ok, sw_ch, done_p, rx_done;

  assign wch     = reg_addr[5 +: CHW];
  assign ch_ok   = !reg_addr[8] && (32'(reg_addr[7:5]) < NUM_CH);
  assign sw_ch   = reg_wr && ch_ok;
  assign done_p  = (st == utd_pkg::ST_DONE);
  assign rx_done = (st == utd_pkg::ST_RXWR) && mem_ack;

  // Lowest channel with a nonzero head wins
  always_comb begin
    pick   = '0;
    pick_v = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (head_reg[i] != utd_pkg::RST_WORD) begin // [R17]
        pick   = CHW'(i);
        pick_v = 1'b1;
      end
    end
  end

  // Descriptor walker and per-channel state words
  always_ff @(posedge clock) begin
    if (srst) begin
      st <= utd_pkg::ST_IDLE;
      for (int i = 0; i < NUM_CH; i++) begin
        head_reg[i]  <= utd_pkg::RST_WORD;
        first_reg[i] <= utd_pkg::RST_WORD;
        curd_reg[i]  <= utd_pkg::RST_WORD;
        curb_reg[i]  <= utd_pkg::RST_WORD;
        scr_reg[i]   <= utd_pkg::RST_WORD;
        len_reg[i]   <= utd_pkg::RST_WORD;
        comp_reg[i]  <= utd_pkg::RST_WORD;
      end
      {mem_req, mem_we, ep_valid, ep_last, ep_zlp, in_pkt, eoq_q} <= '0;
      {mem_addr, mem_wdata, cur, link, bufp, lenw, ctl} <= '0;
      {sopp, sop_ctl, addr} <= '0;
      {bytes, remain, actual} <= '0;
      ep_data <= '0;
      ep_chan <= '0;
      widx    <= '0;
      act     <= '0;
    end else begin
      // Software access to the state words [R10] [R11] [R12]
      if (sw_ch) begin
        case (reg_addr[4:2])
          utd_pkg::W_HEAD:    head_reg[wch]  <= reg_wdata;
          utd_pkg::W_FIRST:   first_reg[wch] <= reg_wdata;
          utd_pkg::W_CURDESC: curd_reg[wch]  <= reg_wdata;
          utd_pkg::W_CURBUF:  curb_reg[wch]  <= reg_wdata;
          utd_pkg::W_SCRATCH: scr_reg[wch]   <= reg_wdata;
          utd_pkg::W_LENGTH:  len_reg[wch]   <= reg_wdata;
          utd_pkg::W_COMP:    ; // Write only acknowledges; engine value kept [R18]
          default: ;
        endcase
      end
      // Live state mirrored into the active channel's words [R12]
      if (st != utd_pkg::ST_IDLE && st != utd_pkg::ST_RXRD && st != utd_pkg::ST_RXWR) begin
        first_reg[act] <= sopp;
        curd_reg[act]  <= cur;
        curb_reg[act]  <= addr;
        scr_reg[act]   <= {16'h0000, bytes};
        len_reg[act]   <= {remain, actual};
      end
      case (st)
        utd_pkg::ST_IDLE: begin
          if (rx_pend_reg) begin
            mem_addr <= rx_desc_reg + utd_pkg::CTL_OFS;
            mem_we   <= 1'b0;
            mem_req  <= 1'b1;
            st       <= utd_pkg::ST_RXRD;
          end else if (pick_v) begin
            act      <= pick;
            ep_chan  <= 3'(pick);
            cur      <= head_reg[pick];
            mem_addr <= head_reg[pick];
            mem_we   <= 1'b0;
            mem_req  <= 1'b1;
            widx     <= '0;
            in_pkt   <= 1'b0;
            st       <= utd_pkg::ST_DESC;
          end
        end
        utd_pkg::ST_DESC: begin
          if (mem_ack) begin
            case (widx)
              2'd0: link <= mem_rdata; // [R15]
              2'd1: bufp <= mem_rdata;
              2'd2: lenw <= mem_rdata; // [R16]
              default: ctl <= mem_rdata;
            endcase
            widx     <= widx + 2'd1;
            mem_addr <= mem_addr + utd_pkg::WORD_INC;
            if (widx == 2'd3) begin
              mem_req <= 1'b0;
              st      <= utd_pkg::ST_PARSE;
            end
          end
        end
        utd_pkg::ST_PARSE: begin
          if (!in_pkt && !(ctl[utd_pkg::FIRST_BIT] && ctl[utd_pkg::OWN_BIT])) begin
            head_reg[act] <= utd_pkg::RST_WORD; // Not owned: stop [R1] [R3]
            st            <= utd_pkg::ST_IDLE;
          end else if (!in_pkt) begin
            // First buffer: offset applies, length loads [R1] [R7] [R16]
            in_pkt  <= 1'b1;
            sopp    <= cur;
            sop_ctl <= ctl;
            actual  <= '0;
            addr    <= bufp + {16'h0000, lenw[31:16]};
            if (ctl[utd_pkg::ZLP_BIT]) begin
              ep_valid <= 1'b1; // No fetch for a zero-length packet [R5]
              ep_zlp   <= 1'b1;
              ep_last  <= 1'b1;
              remain   <= '0;
              bytes    <= '0;
              st       <= utd_pkg::ST_SEND;
            end else begin
              remain   <= ctl[utd_pkg::PLEN_LSB +: utd_pkg::LEN_W];
              bytes    <= lenw[15:0];
              mem_addr <= {bufp[31:2] + 30'(lenw[31:18]) + 30'(lenw[17:16] > 2'(~bufp[1:0])), 2'b00};
              st       <= utd_pkg::ST_BEND;
            end
          end else begin
            addr  <= bufp; // Middle or last buffer [R9]
            bytes <= lenw[15:0];
            st    <= utd_pkg::ST_BEND;
          end
        end
        utd_pkg::ST_BEND: begin
          if (bytes != '0 && remain != '0 && !ep_zlp) begin
            mem_addr <= {addr[31:2], 2'b00};
            mem_we   <= 1'b0;
            mem_req  <= 1'b1;
            st       <= utd_pkg::ST_FETCH;
          end else if (ctl[utd_pkg::LAST_BIT]) begin
            ep_zlp <= 1'b0;
            eoq_q  <= (link == utd_pkg::RST_WORD); // [R2]
            mem_we <= 1'b1;
            mem_req <= 1'b1;
            if (link == utd_pkg::RST_WORD && cur != sopp) begin
              mem_addr  <= cur + utd_pkg::CTL_OFS;
              mem_wdata <= ctl | (32'h1 << utd_pkg::DRAIN_BIT); // [R4] [R14]
              st        <= utd_pkg::ST_WBEOQ;
            end else begin
              mem_addr  <= sopp + utd_pkg::CTL_OFS;
              mem_wdata <= (sop_ctl & ~(32'h1 << utd_pkg::OWN_BIT))
                         | ((link == utd_pkg::RST_WORD) ? (32'h1 << utd_pkg::DRAIN_BIT) : '0);
              st        <= utd_pkg::ST_WBOWN;
            end
          end else if (link == utd_pkg::RST_WORD) begin
            head_reg[act] <= utd_pkg::RST_WORD; // Broken chain ends [R15]
            st            <= utd_pkg::ST_IDLE;
          end else begin
            cur      <= link;
            mem_addr <= link;
            mem_req  <= 1'b1;
            widx     <= '0;
            st       <= utd_pkg::ST_DESC;
          end
        end
        utd_pkg::ST_FETCH: begin
          if (mem_ack) begin
            mem_req  <= 1'b0;
            ep_data  <= mem_rdata[{addr[1:0], 3'b000} +: 8];
            ep_valid <= 1'b1;
            ep_last  <= (remain == 16'h1) || (ctl[utd_pkg::LAST_BIT] && bytes == 16'h1); // [R7]
            st       <= utd_pkg::ST_SEND;
          end
        end
        utd_pkg::ST_SEND: begin
          if (ep_ready) begin
            ep_valid <= 1'b0;
            ep_last  <= 1'b0;
            if (!ep_zlp) begin
              addr   <= addr + 32'h1;
              bytes  <= bytes - 16'h1;
              remain <= remain - 16'h1;
              actual <= actual + 16'h1;
            end
            st <= utd_pkg::ST_BEND;
          end
        end
        utd_pkg::ST_WBEOQ: begin
          if (mem_ack) begin
            mem_addr  <= sopp + utd_pkg::CTL_OFS;
            mem_wdata <= sop_ctl & ~(32'h1 << utd_pkg::OWN_BIT); // [R3] [R14]
            st        <= utd_pkg::ST_WBOWN;
          end
        end
        utd_pkg::ST_WBOWN: begin
          if (mem_ack) begin
            mem_req       <= 1'b0;
            mem_we        <= 1'b0;
            head_reg[act] <= link; // Free packet from the head [R13]
            st            <= utd_pkg::ST_DONE;
          end
        end
        utd_pkg::ST_DONE: begin
          comp_reg[act] <= cur; // [R18]
          in_pkt        <= 1'b0;
          eoq_q         <= 1'b0;
          if (link != utd_pkg::RST_WORD) begin
            cur      <= link;
            mem_addr <= link;
            mem_req  <= 1'b1;
            widx     <= '0;
            st       <= utd_pkg::ST_DESC;
          end else begin
            st <= utd_pkg::ST_IDLE;
          end
        end
        utd_pkg::ST_RXRD: begin
          if (mem_ack) begin
            mem_wdata <= mem_rdata | (32'h1 << utd_pkg::RXAB_BIT); // [R6] [R14]
            mem_we    <= 1'b1;
            st        <= utd_pkg::ST_RXWR;
          end
        end
        utd_pkg::ST_RXWR: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            st      <= utd_pkg::ST_IDLE;
          end
        end
        default: st <= utd_pkg::ST_IDLE;
      endcase
    end
  end

  // Receive abort latch and buffer tally
  always_ff @(posedge clock) begin
    if (srst) begin
      tally_reg   <= '0;
      rx_pend_reg <= 1'b0;
      rx_desc_reg <= '0;
    end else begin
      if (rx_done) begin
        tally_reg <= '0; // [R6]
      end else if (reg_wr && reg_addr == utd_pkg::TALLY_OFS) begin
        tally_reg <= tally_reg + reg_wdata[15:0];
      end
      if (rx_abort && tally_reg != '0 && !rx_pend_reg) begin
        rx_pend_reg <= 1'b1;
        rx_desc_reg <= rx_first_desc;
      end else if (rx_done) begin
        rx_pend_reg <= 1'b0;
      end
    end
  end

  // Sticky interrupt status; set beats clear
  always_ff @(posedge clock) begin
    if (srst) begin
      int_stat_reg <= '0;
      int_mask_reg <= '0;
      irq          <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (done_p && act == CHW'(i)) begin
          int_stat_reg[i] <= 1'b1; // [R18]
        end else if (sw_ch && wch == CHW'(i) && reg_addr[4:2] == utd_pkg::W_COMP
                     && reg_wdata == comp_reg[i]) begin
          int_stat_reg[i] <= 1'b0; // [R18]
        end
      end
      if (rx_done) begin
        int_stat_reg[NUM_CH] <= 1'b1;
      end else if (reg_wr && reg_addr == utd_pkg::INT_STAT_OFS && reg_wdata[NUM_CH]) begin
        int_stat_reg[NUM_CH] <= 1'b0;
      end
      if (reg_wr && reg_addr == utd_pkg::INT_MASK_OFS) begin
        int_mask_reg <= reg_wdata[NUM_CH:0];
      end
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (ch_ok) begin
        case (reg_addr[4:2])
          utd_pkg::W_HEAD:    reg_rdata <= head_reg[wch];
          utd_pkg::W_FIRST:   reg_rdata <= first_reg[wch];
          utd_pkg::W_CURDESC: reg_rdata <= curd_reg[wch];
          utd_pkg::W_CURBUF:  reg_rdata <= curb_reg[wch];
          utd_pkg::W_SCRATCH: reg_rdata <= scr_reg[wch];
          utd_pkg::W_LENGTH:  reg_rdata <= len_reg[wch];
          utd_pkg::W_COMP:    reg_rdata <= comp_reg[wch];
          default: ;
        endcase
      end else if (reg_addr == utd_pkg::INT_STAT_OFS) begin
        reg_rdata <= 32'(int_stat_reg);
      end else if (reg_addr == utd_pkg::INT_MASK_OFS) begin
        reg_rdata <= 32'(int_mask_reg);
      end else if (reg_addr == utd_pkg::TALLY_OFS) begin
        reg_rdata <= {16'h0000, tally_reg};
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence pkt_end_s;
    st == utd_pkg::ST_WBOWN && mem_ack;
  endsequence
  sequence done_s;
    st == utd_pkg::ST_DONE;
  endsequence
  own_clear_a: assert property (st == utd_pkg::ST_WBOWN && mem_req |-> mem_we && !mem_wdata[29]) // [R3]
    else $error("ownership not cleared");
  eoq_set_a: assert property (st == utd_pkg::ST_WBEOQ |-> mem_wdata[28] && mem_addr == cur + 32'hc) // [R4]
    else $error("drained flag write wrong");
  resv_keep_a: assert property (st == utd_pkg::ST_WBEOQ |-> mem_wdata[27:0] == ctl[27:0]) // [R14]
    else $error("reserved bits altered");
  zlp_last_a: assert property (ep_valid && ep_zlp |-> ep_last && st == utd_pkg::ST_SEND) // [R5]
    else $error("zero packet not single");
  trunc_a: assert property (ep_valid && !ep_zlp |-> remain != 16'h0) // [R7]
    else $error("byte sent past length");
  pkt_close_a: assert property (pkt_end_s |=> done_s ##1 int_stat_reg[act]) // [R18]
    else $error("completion not flagged");
  comp_wr_a: assert property (done_s |=> comp_reg[$past(act)] == $past(cur)) // [R18]
    else $error("completion pointer wrong");
  rx_clear_a: assert property (rx_done |=> tally_reg == 16'h0 && !rx_pend_reg) // [R6]
    else $error("tally not zeroed");
  irq_out_a: assert property (irq |-> $past(|(int_stat_reg & int_mask_reg))) // [R18]
    else $error("spurious interrupt");
endmodule : utd_tx_dma
`default_nettype wire

/* File: bench/utd_mem_model.sv */
// Behavioural main memory holding descriptor queues and packet buffers.
// Assumes the engine holds each request steady until its acknowledge cycle.
`timescale 1ns/1ps
`default_nettype none
module utd_mem_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Memory slave side
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata,
  // Pacing and read statistics
  input  wire logic        slow,
  output int               rd_count
);
  logic [31:0] words [0:255];
  int          wait_cnt;

  // One word per acknowledge; read data scrambled outside the ack cycle
  always @(posedge clock) begin
    if (srst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h00000000;
      wait_cnt <= 0;
      rd_count <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_cnt == 0) begin
          mem_ack <= 1'b1;
          wait_cnt <= slow ? 3 : 0;
          if (mem_we) begin
            words[mem_addr[9:2]] <= mem_wdata;
          end else begin
            mem_rdata <= words[mem_addr[9:2]];
            rd_count <= rd_count + 1;
          end
        end else begin
          wait_cnt <= wait_cnt - 1;
        end
      end
    end
  end
endmodule : utd_mem_model
`default_nettype wire

/* File: bench/utd_tx_dma_bench.sv */
// Self-checking bench for the transmit descriptor engine.
// Assumes utd_mem_model as main memory and a randomly stalling endpoint sink.
`timescale 1ns/1ps
`default_nettype none
module utd_tx_dma_bench;
  logic        clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ep_ready = 1'b0;
  logic        rx_abort = 1'b0, slow = 1'b0;
  logic [8:0]  reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h0, rx_first_desc = 32'h0;
  logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, v;
  logic        mem_req, mem_we, mem_ack, ep_valid, ep_last, ep_zlp, irq;
  logic [7:0]  ep_data;
  logic [2:0]  ep_chan;
  logic [15:0] rnd = 16'h6d38, r16, lo;
  int          rd_count, r0, i, n_fail = 0, check_count = 0;
  int          exp_q[$];

  // 20 MHz clock
  always #25 clock = ~clock;

  utd_tx_dma #(.NUM_CH(4)) dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ep_valid(ep_valid), .ep_data(ep_data),
    .ep_last(ep_last), .ep_zlp(ep_zlp), .ep_chan(ep_chan), .ep_ready(ep_ready),
    .rx_abort(rx_abort), .rx_first_desc(rx_first_desc), .irq(irq));
  utd_mem_model mem_i (.clock(clock), .srst(srst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .slow(slow), .rd_count(rd_count));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  function automatic int word(input int a);
    return mem_i.words[a[9:2]];
  endfunction : word
  function automatic int mbyte(input int a);
    return (word(a) >> (8 * (a & 3))) & 255;
  endfunction : mbyte

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task conclude();
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task reg_write(input logic [8:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [8:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask : reg_read
  // Reads until the value appears or the try limit runs out
  task poll(input logic [8:0] a, input logic [31:0] e);
    for (int k = 0; k < 60; k++) begin
      reg_read(a, v);
      if (v === e) break;
    end
  endtask : poll
  task setd(input int a, input int w0, input int w1, input int w2, input int w3);
    mem_i.words[a[9:2]] = w0;
    mem_i.words[a[9:2] + 1] = w1;
    mem_i.words[a[9:2] + 2] = w2;
    mem_i.words[a[9:2] + 3] = w3;
  endtask : setd
  // Reference walk of a queue into the expected endpoint items
  task model_queue(input int ch, input int head);
    int d, w2, w3, plen, off, cnt, zl, b;
    d = head;
    zl = 0;
    cnt = 0;
    plen = 0;
    while (d != 0) begin
      w2 = word(d + 8);
      w3 = word(d + 12);
      off = 0;
      if (w3[31]) begin
        plen = w3 & 32'hffff;
        off = (w2 >> 16) & 32'hffff;
        cnt = 0;
        zl = w3[23];
        if (zl != 0) exp_q.push_back((ch << 10) | 32'h300);
      end
      for (b = 0; zl == 0 && b < (w2 & 32'hffff) && cnt < plen; b++) begin
        cnt++;
        exp_q.push_back((ch << 10) | ((cnt == plen) << 8) | mbyte(word(d + 4) + off + b));
      end
      d = word(d);
    end
  endtask : model_queue
  task run(input int ch, input int head, input int comp);
    model_queue(ch, head);
    reg_write(9'(ch * 32), 32'(head));
    for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge clock);
    poll(9'(ch * 32 + 24), 32'(comp));
    check(v, 32'(comp));
    check(32'(exp_q.size()), 32'h0);
  endtask : run

  // Stalling endpoint sink compared with the reference items
  always @(posedge clock) begin
    rnd <= lfsr_next(rnd);
    ep_ready <= rnd[0] | rnd[3];
    slow <= rnd[5];
    if (!srst && ep_valid === 1'b1 && ep_ready === 1'b1) begin
      check({19'h0, ep_chan, ep_zlp, ep_last, ep_zlp ? 8'h00 : ep_data},
            exp_q.size() > 0 ? exp_q.pop_front() : 32'hffffffff);
    end
  end

  // Watchdog against a stalled engine
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    conclude();
  end

  initial begin
    r16 = 16'h6d38;
    for (i = 0; i < 256; i++) begin
      r16 = lfsr_next(r16);
      lo = r16;
      r16 = lfsr_next(r16);
      mem_i.words[i] = {r16, lo};
    end
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    // Reset state words, status and an unmapped address
    for (i = 0; i < 7; i++) begin
      reg_read(9'(i * 4), v);
      check(v, 32'h0);
    end
    reg_write(9'h1fc, 32'hffffffff);
    reg_read(9'h1fc, v);
    check(v, 32'h0);
    reg_read(utd_pkg::INT_STAT_OFS, v);
    check(v, 32'h0);
    // One-buffer packet with offset, then three buffers truncated at five bytes
    setd(32'h40, 32'h50, 32'h200, 32'h00010004, 32'hea000004);
    setd(32'h50, 32'h60, 32'h210, 32'h2, 32'ha5000005);
    setd(32'h60, 32'h70, 32'h220, 32'h2, 32'h0);
    setd(32'h70, 32'h0, 32'h230, 32'h2, 32'h43000000);
    reg_write(utd_pkg::INT_MASK_OFS, 32'h2);
    run(1, 32'h40, 32'h70);
    check(word(32'h4c), 32'hca000004);
    check(word(32'h5c), 32'h85000005);
    check(word(32'h7c), 32'h53000000);
    // State words left by the last packet of the queue
    reg_read(9'h024, v);
    check(v, 32'h50);
    reg_read(9'h028, v);
    check(v, 32'h70);
    reg_read(9'h034, v);
    check(v, 32'h5);
    reg_read(9'h020, v);
    check(v, 32'h0);
    check(irq, 1'b1);
    reg_write(9'h038, 32'h50);
    repeat (3) @(posedge clock);
    check(irq, 1'b1);
    reg_write(9'h038, 32'h70);
    repeat (3) @(posedge clock);
    check(irq, 1'b0);
    // Zero-length packet on a masked channel
    setd(32'h80, 32'h0, 32'h240, 32'h1, 32'he0800001);
    r0 = rd_count;
    run(2, 32'h80, 32'h80);
    check(32'(rd_count - r0), 32'h4);
    check(word(32'h8c), 32'hd0800001);
    check(irq, 1'b0);
    reg_read(utd_pkg::INT_STAT_OFS, v);
    check(v, 32'h4);
    reg_write(utd_pkg::INT_MASK_OFS, 32'h6);
    repeat (3) @(posedge clock);
    check(irq, 1'b1);
    reg_write(9'h058, 32'h80);
    repeat (3) @(posedge clock);
    check(irq, 1'b0);
    // Receive abort with a nonzero tally
    setd(32'h90, 32'h0, 32'h250, 32'h4, 32'h80000004);
    reg_write(utd_pkg::TALLY_OFS, 32'h3);
    reg_write(utd_pkg::TALLY_OFS, 32'h2);
    reg_read(utd_pkg::TALLY_OFS, v);
    check(v, 32'h5);
    reg_write(utd_pkg::INT_MASK_OFS, 32'h10);
    @(posedge clock);
    rx_abort <= 1'b1;
    rx_first_desc <= 32'h90;
    @(posedge clock);
    rx_abort <= 1'b0;
    poll(utd_pkg::INT_STAT_OFS, 32'h10);
    check(v, 32'h10);
    reg_read(utd_pkg::TALLY_OFS, v);
    check(v, 32'h0);
    check(word(32'h9c), 32'h80080004);
    check(irq, 1'b1);
    reg_write(utd_pkg::INT_STAT_OFS, 32'h10);
    repeat (3) @(posedge clock);
    check(irq, 1'b0);
    conclude();
  end
endmodule : utd_tx_dma_bench
`default_nettype wire
